// File: hw/isp_pkg.sv
// Purpose: Shared constants and types for the serial slave register port
// Assumes: 8-bit register map, 7-bit sub-address
// Notes: Address upper bits are fixed; the low bit comes from a strap
package isp_pkg;
	localparam int ISP_DATA_W = 8;
	localparam int ISP_REG_AW = 7;
	localparam int ISP_FIFO_DEPTH = 16;
	localparam logic [5:0] ISP_ADDR_HI = 6'h2E;
	localparam int ISP_SUB_INC_BIT = 7;
	localparam int ISP_RW_BIT = 0;
	localparam logic [3:0] ISP_BIT_LAST = 4'h7;
	localparam logic [7:0] ISP_RESET_BYTE = 8'h00;
	localparam int ISP_CLK_HZ = 50000000;
	localparam int ISP_SCL_MAX_HZ = 400000;
	localparam int ISP_CYC_PER_SCL = ISP_CLK_HZ / ISP_SCL_MAX_HZ;

	typedef enum logic [2:0] {
		ISP_IDLE,
		ISP_ADDR,
		ISP_SUB,
		ISP_WDATA,
		ISP_RDATA,
		ISP_ACK,
		ISP_MACK,
		ISP_IGNORE
	} isp_state_type;

	typedef enum logic [1:0] {
		ISP_PH_ADDR,
		ISP_PH_SUB,
		ISP_PH_WDATA,
		ISP_PH_RDATA
	} isp_phase_type;
endpackage

// File: hw/isp_fifo.sv
// Purpose: Small synchronous FIFO for written bytes
// Assumes: Single clock, one push and one pop per cycle at most
// Notes: Read data come from a register; full and empty are exact
`timescale 1ns/1ns
module isp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and control
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Write side
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	input wire logic [WIDTH-1:0] wr_data_in,
	// Read side
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic [WIDTH-1:0] rd_data_out
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
		logic [WIDTH-1:0] dout;
		logic dval;
	} isp_fifo_state_type;

	isp_fifo_state_type st_ff;
	isp_fifo_state_type nxt_st;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic push;
	logic pop;
	logic load;

	always_comb begin
		wr_ready_out = (st_ff.cnt != (AW+1)'(DEPTH));
		rd_valid_out = st_ff.dval;
		rd_data_out = st_ff.dout;
		push = wr_valid_in && wr_ready_out;
		load = (st_ff.cnt != '0) && (!st_ff.dval || rd_ready_in);
		pop = load;
		nxt_st = st_ff;
		if (rd_ready_in && st_ff.dval) begin
			nxt_st.dval = 1'b0;
		end
		if (load) begin
			nxt_st.dout = mem_ff[st_ff.rp];
			nxt_st.dval = 1'b1;
			nxt_st.rp = st_ff.rp + 1'b1;
		end
		if (push) begin
			nxt_st.wp = st_ff.wp + 1'b1;
		end
		nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			st_ff <= '0;
		end else if (clk_en_in) begin
			st_ff <= nxt_st;
			if (push) begin
				mem_ff[st_ff.wp] <= wr_data_in;
			end
		end
	end
endmodule

// File: hw/isp_port.sv
// Purpose: Serial two-wire slave port into an 8-bit register map
// Assumes: Serial clock and data are sampled by ref_clk_in, far below its rate
// Notes: Written bytes leave through a FIFO; read bytes come from rd_data_in
`timescale 1ns/1ns
// Overview of operation
// - Mode pin high selects this serial port
// - Data fall with clock high starts frame
// - Compare seven address bits with own
// - Address low bit follows the strap pin
// - Address bytes B8/B9 or BA/BB
// - Receiver pulls data low during acknowledge
// - Acknowledge address, sub-address, each written byte
// - Sub-address: seven register bits, increment flag
// - Increment flag advances register after bytes
// - Master acknowledges reads, no-acknowledge ends
// - Bytes of eight bits, MSB first
// - Clock stretching stalls the transmitter
// - Unacknowledged address leaves data high
// - Data rise with clock high stops frame
// - Serial clock up to fast rate
module isp_port
	import isp_pkg::*;
#(
	parameter int FIFO_DEPTH = isp_pkg::ISP_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Pads
	input wire logic mode_sel_in,
	input wire logic address_strap_pin_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	output logic scl_out,
	output logic scl_oe_out,
	// Written bytes
	output logic wr_valid_out,
	input wire logic wr_ready_in,
	output logic [isp_pkg::ISP_REG_AW-1:0] wr_addr_out,
	output logic [isp_pkg::ISP_DATA_W-1:0] wr_data_out,
	// Read bytes
	output logic rd_req_out,
	output logic [isp_pkg::ISP_REG_AW-1:0] rd_addr_out,
	input wire logic [isp_pkg::ISP_DATA_W-1:0] rd_data_in,
	// Status
	output logic busy_out,
	output logic addressed_out
);
	import isp_pkg::*;

	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [1:0] mode_s;
		logic [1:0] strap_s;
		logic scl_d;
		logic sda_d;
		isp_state_type st;
		isp_phase_type ph;
		logic [3:0] bitc;
		logic [7:0] sh;
		logic [6:0] reg_a;
		logic inc;
		logic ack_drv;
		logic sda_o;
		logic busy;
		logic addressed;
		logic rd_req;
		logic push;
		logic [6:0] push_a;
		logic [7:0] push_d;
	} isp_state_all_type;

	isp_state_all_type st_ff;
	isp_state_all_type nxt_st;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [7:0] own_w;
	logic fifo_ready;
	logic [14:0] fifo_word;

	// Synchronised pad levels, read only after the second stage
	assign scl = st_ff.scl_s[1];
	assign sda = st_ff.sda_s[1];
	assign scl_rise = scl && !st_ff.scl_d;
	assign scl_fall = !scl && st_ff.scl_d;
	assign start_det = st_ff.mode_s[1] && scl && st_ff.scl_d && st_ff.sda_d && !sda;
	assign stop_det = st_ff.mode_s[1] && scl && st_ff.scl_d && !st_ff.sda_d && sda;
	assign own_w = {ISP_ADDR_HI, st_ff.strap_s[1], 1'b0};

	// Written bytes are queued; a full queue stretches the clock instead of dropping
	isp_fifo #(
		.WIDTH(15),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk_in(ref_clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.wr_valid_in(st_ff.push),
		.wr_ready_out(fifo_ready),
		.wr_data_in({st_ff.push_a, st_ff.push_d}),
		.rd_valid_out(wr_valid_out),
		.rd_ready_in(wr_ready_in),
		.rd_data_out(fifo_word)
	);

	assign wr_addr_out = fifo_word[14:8];
	assign wr_data_out = fifo_word[7:0];

	always_comb begin
		nxt_st = st_ff;
		nxt_st.scl_s = {st_ff.scl_s[0], scl_in};
		nxt_st.sda_s = {st_ff.sda_s[0], sda_in};
		nxt_st.mode_s = {st_ff.mode_s[0], mode_sel_in};
		nxt_st.strap_s = {st_ff.strap_s[0], address_strap_pin_in};
		nxt_st.scl_d = scl;
		nxt_st.sda_d = sda;
		nxt_st.rd_req = 1'b0;
		if (st_ff.push && fifo_ready) begin
			nxt_st.push = 1'b0;
		end
		if (!st_ff.mode_s[1]) begin
			// Pads belong to the other serial port
			nxt_st.st = ISP_IDLE;
			nxt_st.sda_o = 1'b1;
			nxt_st.busy = 1'b0;
			nxt_st.addressed = 1'b0;
		end else if (start_det) begin
			// Plain or repeated start: restart address capture
			nxt_st.st = ISP_ADDR;
			nxt_st.ph = ISP_PH_ADDR;
			nxt_st.bitc = '0;
			nxt_st.busy = 1'b1;
			nxt_st.addressed = 1'b0;
			nxt_st.sda_o = 1'b1;
		end else if (stop_det) begin
			nxt_st.st = ISP_IDLE;
			nxt_st.busy = 1'b0;
			nxt_st.addressed = 1'b0;
			nxt_st.sda_o = 1'b1;
		end else begin
			unique case (st_ff.st)
				ISP_IDLE, ISP_IGNORE: begin
					nxt_st.sda_o = 1'b1;
				end
				ISP_ADDR, ISP_SUB, ISP_WDATA: begin
					if (scl_rise) begin
						nxt_st.sh = {st_ff.sh[6:0], sda};
						nxt_st.bitc = st_ff.bitc + 4'h1;
					end
					if (scl_fall && st_ff.bitc == 4'h8) begin
						nxt_st.bitc = '0;
						nxt_st.st = ISP_ACK;
						nxt_st.sda_o = 1'b0;
						if (st_ff.st == ISP_ADDR) begin
							if (st_ff.sh[7:1] != own_w[7:1]) begin
								nxt_st.st = ISP_IGNORE;
								nxt_st.sda_o = 1'b1;
							end else begin
								nxt_st.addressed = 1'b1;
								nxt_st.ph = st_ff.sh[ISP_RW_BIT] ? ISP_PH_RDATA : ISP_PH_SUB;
								if (st_ff.sh[ISP_RW_BIT]) begin
									nxt_st.rd_req = 1'b1;
								end
							end
						end else if (st_ff.st == ISP_SUB) begin
							nxt_st.reg_a = st_ff.sh[6:0];
							nxt_st.inc = st_ff.sh[ISP_SUB_INC_BIT];
							nxt_st.ph = ISP_PH_WDATA;
						end else begin
							nxt_st.push = 1'b1;
							nxt_st.push_a = st_ff.reg_a;
							nxt_st.push_d = st_ff.sh;
							if (st_ff.inc) begin
								nxt_st.reg_a = st_ff.reg_a + 7'h01;
							end
						end
					end
				end
				ISP_ACK: begin
					// Release after the acknowledge pulse falls; hold clock while queue is full
					if (scl_fall && !(st_ff.push && !fifo_ready)) begin
						if (st_ff.ph == ISP_PH_RDATA) begin
							nxt_st.st = ISP_RDATA;
							nxt_st.sh = {rd_data_in[6:0], 1'b0};
							nxt_st.sda_o = rd_data_in[7];
							nxt_st.bitc = 4'h1;
						end else begin
							nxt_st.st = (st_ff.ph == ISP_PH_SUB) ? ISP_SUB : ISP_WDATA;
							nxt_st.sda_o = 1'b1;
						end
					end
				end
				ISP_RDATA: begin
					if (scl_fall) begin
						if (st_ff.bitc == 4'h8) begin
							nxt_st.sda_o = 1'b1;
							nxt_st.st = ISP_MACK;
							if (st_ff.inc) begin
								nxt_st.reg_a = st_ff.reg_a + 7'h01;
							end
						end else begin
							nxt_st.sda_o = st_ff.sh[7];
							nxt_st.sh = {st_ff.sh[6:0], 1'b0};
							nxt_st.bitc = st_ff.bitc + 4'h1;
						end
					end
				end
				ISP_MACK: begin
					if (scl_rise) begin
						if (sda) begin
							nxt_st.st = ISP_IGNORE;
						end else begin
							nxt_st.rd_req = 1'b1;
							nxt_st.st = ISP_ACK;
							nxt_st.sda_o = 1'b1;
						end
					end
				end
				default: begin
					nxt_st.st = ISP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			st_ff <= '0;
			st_ff.scl_s <= 2'h3;
			st_ff.sda_s <= 2'h3;
			st_ff.scl_d <= 1'b1;
			st_ff.sda_d <= 1'b1;
			st_ff.sda_o <= 1'b1;
			st_ff.st <= ISP_IDLE;
			st_ff.ph <= ISP_PH_ADDR;
		end else if (clk_en_in) begin
			st_ff <= nxt_st;
		end
	end

	// Open drain: drive only a low level
	assign sda_out = 1'b0;
	assign sda_oe_out = !st_ff.sda_o;
	// Stretch while a written byte waits for queue room
	assign scl_out = 1'b0;
	assign scl_oe_out = (st_ff.st == ISP_ACK) && st_ff.push && !fifo_ready && !scl;
	assign rd_req_out = st_ff.rd_req;
	assign rd_addr_out = st_ff.reg_a;
	assign busy_out = st_ff.busy;
	assign addressed_out = st_ff.addressed;
endmodule

// File: tb/isp_port_assertions.sv
// Purpose: Bus-level checks for the serial slave port
// Assumes: Pads reach ref_clk_in through short synchronisers
// Notes: Windows allow a few clocks of sampling latency
`timescale 1ns/1ns
module isp_port_assertions (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// Pads
	input wire logic mode_sel_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic scl_out,
	input wire logic scl_oe_out,
	// Data and status
	input wire logic wr_valid_out,
	input wire logic wr_ready_in,
	input wire logic [6:0] wr_addr_out,
	input wire logic [7:0] wr_data_out,
	input wire logic rd_req_out,
	input wire logic busy_out,
	input wire logic addressed_out
);
	default clocking dc @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	AST_MODE: assert property (!mode_sel_in [*4] |-> !sda_oe_out && !scl_oe_out)
		else $error("pads driven in other mode");
	AST_OD: assert property (sda_oe_out |-> !sda_out && busy_out)
		else $error("data pad not open drain");
	AST_ACK: assert property (scl_in [*2] |-> $stable(sda_oe_out))
		else $error("data changed with clock high");
	AST_START: assert property (scl_in && $fell(sda_in) && mode_sel_in |-> ##[1:6] busy_out)
		else $error("start not seen");
	AST_STOP: assert property (scl_in && $rose(sda_in) && mode_sel_in |-> ##[1:6] !busy_out)
		else $error("stop not seen");
	AST_IDLE: assert property (!busy_out |-> !sda_oe_out && !scl_oe_out)
		else $error("pads driven while idle");
	AST_STRETCH: assert property (scl_oe_out |-> !scl_out && wr_valid_out)
		else $error("stretch without full buffer");
	AST_RDPULSE: assert property (rd_req_out |=> !rd_req_out)
		else $error("read request too long");
	AST_RDQUAL: assert property (rd_req_out |-> addressed_out && busy_out)
		else $error("read request while not addressed");
	AST_WRHOLD: assert property (wr_valid_out && !wr_ready_in |=>
		wr_valid_out && $stable(wr_data_out) && $stable(wr_addr_out))
		else $error("queued byte lost");
	cover property (scl_oe_out);
	cover property ($rose(rd_req_out));
	cover property ($fell(busy_out));
endmodule
bind isp_port isp_port_assertions chk_u (.ref_clk_in, .sys_rst_in, .mode_sel_in, .scl_in,
	.sda_in, .sda_out, .sda_oe_out, .scl_out, .scl_oe_out, .wr_valid_out, .wr_ready_in,
	.wr_addr_out, .wr_data_out, .rd_req_out, .busy_out, .addressed_out);

// File: tb/isp_bus_master.sv
// Purpose: Behavioural two-wire bus master
// Assumes: Pull-ups outside; a high pull output means pulling low
// Notes: Clock period 160 ns, clock stands high between frames
`timescale 1ns/1ns
module isp_bus_master (
	// Pulls
	output logic scl_pull_out,
	output logic sda_pull_out,
	// Wire levels
	input wire logic scl_in,
	input wire logic sda_in
);
	initial begin
		scl_pull_out = 0;
		sda_pull_out = 0;
	end
	task automatic clk_high();
		scl_pull_out = 0;
		for (int n = 0; n < 400 && scl_in !== 1'b1; n++)
			#20;
		#40;
	endtask
	task automatic start();
		#20;
		sda_pull_out = 0;
		#100;
		clk_high();
		sda_pull_out = 1;
		#80;
		scl_pull_out = 1;
	endtask
	task automatic stop();
		#20;
		sda_pull_out = 1;
		#100;
		clk_high();
		sda_pull_out = 0;
		#160;
	endtask
	// Data moves 20 ns after the fall so it never looks like a start or stop
	task automatic bit_io(input logic b, output logic s);
		#20;
		sda_pull_out = !b;
		#100;
		clk_high();
		s = sda_in;
		scl_pull_out = 1;
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask
	task automatic get_byte(output logic [7:0] d, input logic more);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(!more, s);
	endtask
endmodule

// File: tb/test_isp_port.sv
// Purpose: Self-checking bench for the serial slave port
// Assumes: Master model on the far side, pull-ups on both lines
// Notes: Small buffer depth makes clock stretching quick to reach
`timescale 1ns/1ns
module test_isp_port;
	import isp_pkg::*;
	localparam int DEPTH = 4;
	logic ref_clk_in = 0;
	logic sys_rst_in = 1;
	logic mode = 1;
	logic strap = 0;
	logic ready = 0;
	logic m_scl, m_sda, sda_oe, scl_oe, wr_valid, rd_req, busy, addressed;
	logic [6:0] wr_addr, rd_addr;
	logic [7:0] wr_data, rd_data;
	int n_mismatch = 0;
	int n_checks = 0;
	wire scl = !(m_scl | scl_oe);
	wire sda = !(m_sda | sda_oe);
	function automatic logic [7:0] rv(input logic [6:0] a);
		return {a, 1'b1} ^ 8'hA5;
	endfunction
	assign rd_data = rv(rd_addr);
	always #10 ref_clk_in = ~ref_clk_in;
	isp_bus_master m (.scl_pull_out(m_scl), .sda_pull_out(m_sda), .scl_in(scl), .sda_in(sda));
	isp_port #(.FIFO_DEPTH(DEPTH)) dut_u (.ref_clk_in, .sys_rst_in, .clk_en_in(1'b1),
		.mode_sel_in(mode), .address_strap_pin_in(strap), .scl_in(scl), .sda_in(sda),
		.sda_out(), .sda_oe_out(sda_oe), .scl_out(), .scl_oe_out(scl_oe),
		.wr_valid_out(wr_valid), .wr_ready_in(ready), .wr_addr_out(wr_addr),
		.wr_data_out(wr_data), .rd_req_out(rd_req), .rd_addr_out(rd_addr),
		.rd_data_in(rd_data), .busy_out(busy), .addressed_out(addressed));
	task automatic chk(input string w, input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic pop(input logic [6:0] ea, input logic [7:0] ed);
		for (int n = 0; n < 2000 && wr_valid !== 1'b1; n++)
			@(posedge ref_clk_in);
		#2;
		chk("wr addr", {1'b0, wr_addr}, {1'b0, ea});
		chk("wr data", wr_data, ed);
		ready = 1;
		@(posedge ref_clk_in);
		#2;
		ready = 0;
		@(posedge ref_clk_in);
		#2;
	endtask
	// Register address starts at 7E to show the 7-bit wrap
	task automatic t_write();
		logic a;
		m.start();
		m.put_byte(8'hB8, a);
		chk("ack addr", {7'h0, a}, 8'h01);
		m.put_byte(8'hFE, a);
		chk("ack sub", {7'h0, a}, 8'h01);
		chk("addressed", {7'h0, addressed}, 8'h01);
		// Queue holds DEPTH words plus its output register, so DEPTH+2 bytes force a stretch
		fork
			for (int i = 0; i < DEPTH + 2; i++) begin
				m.put_byte(8'h30 + 8'(i), a);
				chk("ack data", {7'h0, a}, 8'h01);
			end
			begin
				for (int n = 0; n < 3000 && scl_oe !== 1'b1; n++)
					@(posedge ref_clk_in);
				#2;
				chk("stretch", {7'h0, scl_oe}, 8'h01);
				for (int i = 0; i < DEPTH + 2; i++)
					pop(7'h7E + 7'(i), 8'h30 + 8'(i));
			end
		join
		m.stop();
		chk("busy", {7'h0, busy}, 8'h00);
	endtask
	task automatic t_read();
		logic a;
		logic [7:0] d;
		strap = 1;
		m.start();
		m.put_byte(8'hBA, a);
		chk("ack addr", {7'h0, a}, 8'h01);
		m.put_byte(8'h90, a);
		m.start();
		m.put_byte(8'hBB, a);
		chk("ack read", {7'h0, a}, 8'h01);
		for (int i = 0; i < 3; i++) begin
			m.get_byte(d, i < 2);
			chk("rd data", d, rv(7'h10 + 7'(i)));
		end
		m.stop();
		// Without the increment flag every byte comes from one register
		m.start();
		m.put_byte(8'hBA, a);
		m.put_byte(8'h05, a);
		chk("ack sub", {7'h0, a}, 8'h01);
		m.start();
		m.put_byte(8'hBB, a);
		for (int i = 0; i < 2; i++) begin
			m.get_byte(d, i < 1);
			chk("rd fixed", d, rv(7'h05));
		end
		m.stop();
	endtask
	task automatic t_nomatch();
		logic a;
		m.start();
		m.put_byte(8'hB8, a);
		chk("ack other", {7'h0, a}, 8'h00);
		m.put_byte(8'hBA, a);
		chk("ack ignored", {7'h0, a}, 8'h00);
		chk("addressed", {7'h0, addressed}, 8'h00);
		m.stop();
	endtask
	task automatic t_mode();
		logic a;
		mode = 0;
		m.start();
		m.put_byte(8'hBA, a);
		chk("ack mode", {7'h0, a}, 8'h00);
		chk("busy mode", {7'h0, busy}, 8'h00);
		m.stop();
		mode = 1;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk_in);
		#2;
		sys_rst_in = 0;
		repeat (4) @(posedge ref_clk_in);
		#2;
		t_write();
		t_read();
		t_nomatch();
		t_mode();
		conclude();
	end
	initial begin
		#200000;
		n_mismatch++;
		conclude();
	end
endmodule
